// [rtl/lsmp_consts.svh]
// Summary of operation
// - Linked start picks first segment by index zero to three and begins there.
// - Segment target is absolute destination when selector 0, relative distance when 1.
// - All segments use shared start velocity, ramp up and ramp down times.
// - Each segment holds its own running speed, used as its plateau velocity.
// - Chain flag 0 stops at segment end; 1 continues into next segment.
// - Segment three has no chain flag; it always ends the motion.
// - Linked motion may start at any segment.
// - Motion ramps from start velocity to segment speed over ramp up time.
// - Unchained segment ramps down to stop exactly at its destination or distance.
// - Chained segment ramps down before its end to a slower next speed; a faster next speed is reached in the next segment.
// - Rising speed uses ramp up time, falling speed uses ramp down time.
// - Too-short profiles are detected; peak speed and ramps are reduced.
// - Adjusted profiles keep final position and try to keep ramp rates.
// - Short last segment may stop sharply but at the correct position.
// - All segments travel in the direction of the first segment executed.
// - Mixed-direction start is refused without motion; immediate start flags error.
// - Mixed-direction start in a sequence sets alarm 70h and ends the sequence.
// - Start returns at once; further commands are accepted while moving.
// - Other motion starts are held off while a linked motion runs.
// - Motion-active and motion-done status are exposed for the commander to poll.
// - A wait instruction suspends the sequence until current motion finishes.
`ifndef LSMP_CONSTS_SVH
`define LSMP_CONSTS_SVH

`define LSMP_OFS_CTRL 8'h00
`define LSMP_OFS_STATUS 8'h04
`define LSMP_OFS_START_VEL 8'h08
`define LSMP_OFS_RAMP_UP 8'h0c
`define LSMP_OFS_RAMP_DOWN 8'h10
`define LSMP_OFS_POSITION 8'h14
`define LSMP_OFS_SEG_BASE 2'h1

`define LSMP_CTRL_START 0
`define LSMP_CTRL_INDEX_LO 1
`define LSMP_CTRL_SEQ 3
`define LSMP_CTRL_WAIT 4
`define LSMP_CTRL_CLEAR 5

`define LSMP_RST_START_VEL 16'h0064
`define LSMP_RST_RAMP 16'h0064
`define LSMP_ALARM_MIXDIR 8'h70

`define LSMP_CLK_HZ 32'h02faf080
`define LSMP_TICK_US 1000
`define LSMP_TICK_CYC ((50000000 / 1000000) * `LSMP_TICK_US)
`define LSMP_BRAKE_K 64'h00000000000007d0

`endif

// [rtl/lsmp_divider.sv]
`timescale 1ns/100ps
module lsmp_divider (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [31:0] num,
    input wire logic [15:0] den,
    output logic [31:0] quot,
    output logic done
);
    logic [16:0] rem_r;
    logic [31:0] quot_r;
    logic [15:0] den_r;
    logic [5:0] cnt_r;
    logic done_r;

    // Restoring division, one quotient bit a cycle; zero divisor gives all ones
    wire [16:0] trial = {rem_r[15:0], quot_r[31]};
    wire take = trial >= {1'b0, den_r};

    always_ff @(posedge clk) begin
        if (srst) begin
            rem_r <= 17'h00000;
            quot_r <= 32'h00000000;
            den_r <= 16'h0000;
            cnt_r <= 6'h00;
            done_r <= 1'b0;
        end else if (start) begin
            rem_r <= 17'h00000;
            quot_r <= num;
            den_r <= den;
            cnt_r <= 6'h20;
            done_r <= 1'b0;
        end else if (cnt_r != 6'h00) begin
            rem_r <= take ? trial - {1'b0, den_r} : trial;
            quot_r <= {quot_r[30:0], take};
            cnt_r <= cnt_r - 6'h01;
            done_r <= (cnt_r == 6'h01);
        end else begin
            done_r <= 1'b0;
        end
    end

    assign quot = quot_r;
    assign done = done_r;
endmodule

// [rtl/lsmp_pkg.sv]
package lsmp_pkg;

typedef struct packed {
    logic [15:0] speed;
    logic [31:0] target;
    logic abs_rel;
    logic chain;
} lsmp_seg_t;

typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_DIV_A = 5'b00100,
    ST_DIV_D = 5'b01000,
    ST_RUN = 5'b10000
} lsmp_state_t;

endpackage

// [rtl/lsmp_profiler.sv]
`timescale 1ns/100ps
`include "lsmp_consts.svh"
module lsmp_profiler #(
    parameter int TICK_CYC = `LSMP_TICK_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic step_out,
    output logic dir_out,
    output logic motion_active_flag,
    output logic motion_done_flag
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = ((a[7:6] == `LSMP_OFS_SEG_BASE) ? (a[3:2] != 2'h3) : (a <= `LSMP_OFS_POSITION))
            && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
        end
    endfunction

    function automatic logic [15:0] sat_rate(input logic [31:0] q);
        sat_rate = (q == 32'h00000000) ? 16'h0001 : (q[31:16] != 16'h0000) ? 16'hffff : q[15:0];
    endfunction

    function automatic logic [15:0] floor1(input logic [15:0] v);
        floor1 = (v == 16'h0000) ? 16'h0001 : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r, wdata_r;
    logic [7:0] awaddr_r;
    logic [3:0] wstrb_r;

    lsmp_pkg::lsmp_seg_t seg_live [4];
    lsmp_pkg::lsmp_seg_t seg_snap [4];
    logic [15:0] vs_r, ta_r, td_r, vs_s, ta_s, td_s;
    lsmp_pkg::lsmp_state_t state_r;
    logic signed [31:0] pos_r, sim_r;
    logic signed [31:0] ends_r [4];
    logic [1:0] cur_r, walk_r;
    logic seen_pos_r, seen_neg_r, dir_r, seq_s;
    logic [15:0] vel_r, ar_r, dr_r;
    logic active_r, done_r, cmd_err_r, wait_r, seq_term_r;
    logic [7:0] alarm_r;
    logic [31:0] tick_cnt_r;
    logic tick_r, div_start_r;

    ////////////////////////////////////////////////////////////////////////
    // Write channel decode
    wire wr_go = !awready_r && !wready_r && !bvalid_r;
    wire wr_ok = reg_hit(awaddr_r);
    wire wr_en = wr_go && wr_ok;
    wire wr_seg = awaddr_r[7:6] == `LSMP_OFS_SEG_BASE;
    wire [1:0] wr_idx = awaddr_r[5:4];
    wire [1:0] wr_fld = awaddr_r[3:2];
    wire wr_ctrl = wr_en && awaddr_r == `LSMP_OFS_CTRL && wstrb_r[0];
    wire start_req = wr_ctrl && wdata_r[`LSMP_CTRL_START];
    wire wait_req = wr_ctrl && wdata_r[`LSMP_CTRL_WAIT];
    wire clr_req = wr_ctrl && wdata_r[`LSMP_CTRL_CLEAR];
    wire idle = state_r == lsmp_pkg::ST_IDLE;
    wire start_go = start_req && idle;
    wire start_busy = start_req && !idle;

    // Read channel decode
    wire [1:0] rd_idx = s_axi_araddr[5:4];
    wire [1:0] rd_fld = s_axi_araddr[3:2];
    wire [31:0] rd_seg = (rd_fld == 2'h0) ? {16'h0000, seg_live[rd_idx].speed}
                       : (rd_fld == 2'h1) ? seg_live[rd_idx].target
                       : {30'h00000000, seg_live[rd_idx].chain, seg_live[rd_idx].abs_rel};
    wire [31:0] rd_status = {16'h0000, alarm_r, 3'h0, seq_term_r, wait_r, cmd_err_r,
                             done_r, active_r};
    wire [31:0] rd_word = (s_axi_araddr[7:6] == `LSMP_OFS_SEG_BASE) ? rd_seg
                        : (s_axi_araddr == `LSMP_OFS_STATUS) ? rd_status
                        : (s_axi_araddr == `LSMP_OFS_START_VEL) ? {16'h0000, vs_r}
                        : (s_axi_araddr == `LSMP_OFS_RAMP_UP) ? {16'h0000, ta_r}
                        : (s_axi_araddr == `LSMP_OFS_RAMP_DOWN) ? {16'h0000, td_r}
                        : (s_axi_araddr == `LSMP_OFS_POSITION) ? pos_r
                        : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Direction walk over the captured chain
    lsmp_pkg::lsmp_seg_t w_seg;
    assign w_seg = seg_snap[walk_r];
    wire signed [31:0] w_trav = w_seg.abs_rel ? w_seg.target : w_seg.target - sim_r;
    wire signed [31:0] w_end = sim_r + w_trav;
    wire w_more = w_seg.chain && walk_r != 2'h3;
    wire w_pos = seen_pos_r || w_trav > 0;
    wire w_neg = seen_neg_r || w_trav < 0;
    wire w_mixed = w_pos && w_neg;

    // Profile evaluation for the running segment
    lsmp_pkg::lsmp_seg_t c_seg;
    assign c_seg = seg_snap[cur_r];
    wire c_more = c_seg.chain && cur_r != 2'h3;
    wire [1:0] nxt_idx = cur_r + 2'h1;
    wire signed [31:0] rem = dir_r ? ends_r[cur_r] - pos_r : pos_r - ends_r[cur_r];
    wire at_end = rem <= 0;
    wire [15:0] run_sp = floor1(c_seg.speed);
    wire [15:0] vend = floor1(c_more ? seg_snap[nxt_idx].speed : vs_s);
    wire [31:0] v_sq = vel_r * vel_r;
    wire [31:0] e_sq = vend * vend;
    wire [63:0] brake_need = `LSMP_BRAKE_K * {48'h000000000000, dr_r} * {32'h00000000, rem};
    // Start braking once remaining travel no longer covers the ramp down
    wire brake = vel_r > vend && {32'h00000000, v_sq - e_sq} >= brake_need;
    wire [15:0] lo_tgt = brake ? vend : run_sp;
    wire [15:0] v_down = (vel_r - lo_tgt <= dr_r) ? lo_tgt : vel_r - dr_r;
    wire [15:0] v_up = (run_sp - vel_r <= ar_r) ? run_sp : vel_r + ar_r;
    wire [15:0] sp_first = seg_snap[walk_r].speed;
    wire [15:0] ramp_diff = (floor1(sp_first) > vs_s) ? floor1(sp_first) - vs_s : 16'h0000;
    wire [31:0] quot;
    wire div_done;
    wire step_pulse;
    wire step_en = state_r == lsmp_pkg::ST_RUN && !at_end;

    lsmp_divider u_div (
        .clk(clk),
        .srst(srst),
        .start(div_start_r),
        .num({16'h0000, ramp_diff}),
        .den(state_r == lsmp_pkg::ST_DIV_A ? ta_s : td_s),
        .quot(quot),
        .done(div_done)
    );

    lsmp_step_gen u_step (
        .clk(clk),
        .srst(srst),
        .en(step_en),
        .vel(vel_r),
        .step(step_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    always_ff @(posedge clk) begin
        if (srst) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awready_r <= 1'b0;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_r) begin
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? 2'h0 : 2'h2;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h00000000;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= reg_hit(s_axi_araddr) ? rd_word : 32'h00000000;
            rresp_r <= reg_hit(s_axi_araddr) ? 2'h0 : 2'h2;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Live parameter registers; motion runs from the snapshot only
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_seg
            wire hit = wr_en && wr_seg && wr_idx == gi;
            always_ff @(posedge clk) begin
                if (srst) begin
                    seg_live[gi] <= '0;
                end else if (hit && wr_fld == 2'h0) begin
                    seg_live[gi].speed <= 16'(merge({16'h0000, seg_live[gi].speed}, wdata_r,
                                                wstrb_r));
                end else if (hit && wr_fld == 2'h1) begin
                    seg_live[gi].target <= merge(seg_live[gi].target, wdata_r, wstrb_r);
                end else if (hit && wr_fld == 2'h2 && wstrb_r[0]) begin
                    seg_live[gi].abs_rel <= wdata_r[0];
                    // Last segment keeps its chain flag at zero
                    seg_live[gi].chain <= (gi != 3) && wdata_r[1];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            vs_r <= `LSMP_RST_START_VEL;
            ta_r <= `LSMP_RST_RAMP;
            td_r <= `LSMP_RST_RAMP;
        end else if (wr_en && !wr_seg) begin
            if (awaddr_r == `LSMP_OFS_START_VEL) vs_r <= 16'(merge({16'h0000, vs_r}, wdata_r, wstrb_r));
            if (awaddr_r == `LSMP_OFS_RAMP_UP) ta_r <= 16'(merge({16'h0000, ta_r}, wdata_r, wstrb_r));
            if (awaddr_r == `LSMP_OFS_RAMP_DOWN) td_r <= 16'(merge({16'h0000, td_r}, wdata_r, wstrb_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ramp tick divider
    always_ff @(posedge clk) begin
        if (srst || state_r != lsmp_pkg::ST_RUN) begin
            tick_cnt_r <= 32'h00000000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= tick_cnt_r == 32'(TICK_CYC - 1);
            tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYC - 1)) ? 32'h00000000 : tick_cnt_r + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= lsmp_pkg::ST_IDLE;
            for (int i = 0; i < 4; i++) begin
                seg_snap[i] <= '0;
                ends_r[i] <= 32'sh00000000;
            end
            {vs_s, ta_s, td_s} <= 48'h000000000000;
            pos_r <= 32'sh00000000;
            sim_r <= 32'sh00000000;
            cur_r <= 2'h0;
            walk_r <= 2'h0;
            {seen_pos_r, seen_neg_r, dir_r, seq_s} <= 4'h0;
            {vel_r, ar_r, dr_r} <= 48'h000000000000;
            {active_r, done_r, cmd_err_r, wait_r, seq_term_r} <= 5'h00;
            alarm_r <= 8'h00;
            div_start_r <= 1'b0;
        end else begin
            div_start_r <= 1'b0;
            if (step_pulse) pos_r <= dir_r ? pos_r + 32'sh1 : pos_r - 32'sh1;
            if (clr_req) begin
                cmd_err_r <= 1'b0;
                seq_term_r <= 1'b0;
                alarm_r <= 8'h00;
            end
            if (start_busy) cmd_err_r <= 1'b1;
            wait_r <= (wait_r || wait_req) && active_r;
            unique case (state_r)
                lsmp_pkg::ST_IDLE: begin
                    if (start_go) begin
                        seg_snap <= seg_live;
                        {vs_s, ta_s, td_s} <= {vs_r, ta_r, td_r};
                        walk_r <= wdata_r[`LSMP_CTRL_INDEX_LO +: 2];
                        cur_r <= wdata_r[`LSMP_CTRL_INDEX_LO +: 2];
                        seq_s <= wdata_r[`LSMP_CTRL_SEQ];
                        sim_r <= pos_r;
                        {seen_pos_r, seen_neg_r} <= 2'h0;
                        active_r <= 1'b1;
                        done_r <= 1'b0;
                        state_r <= lsmp_pkg::ST_CHECK;
                    end
                end
                lsmp_pkg::ST_CHECK: begin
                    ends_r[walk_r] <= w_end;
                    sim_r <= w_end;
                    seen_pos_r <= w_pos;
                    seen_neg_r <= w_neg;
                    if (w_mixed) begin
                        // Refused before any step is issued
                        state_r <= lsmp_pkg::ST_IDLE;
                        active_r <= 1'b0;
                        done_r <= 1'b1;
                        if (seq_s) begin
                            alarm_r <= `LSMP_ALARM_MIXDIR;
                            seq_term_r <= 1'b1;
                        end else begin
                            cmd_err_r <= 1'b1;
                        end
                    end else if (w_more) begin
                        walk_r <= walk_r + 2'h1;
                    end else begin
                        dir_r <= !w_neg;
                        walk_r <= cur_r;
                        div_start_r <= 1'b1;
                        state_r <= lsmp_pkg::ST_DIV_A;
                    end
                end
                lsmp_pkg::ST_DIV_A: begin
                    if (div_done) begin
                        ar_r <= sat_rate(quot);
                        div_start_r <= 1'b1;
                        state_r <= lsmp_pkg::ST_DIV_D;
                    end
                end
                lsmp_pkg::ST_DIV_D: begin
                    if (div_done) begin
                        dr_r <= sat_rate(quot);
                        vel_r <= floor1(vs_s);
                        state_r <= lsmp_pkg::ST_RUN;
                    end
                end
                lsmp_pkg::ST_RUN: begin
                    if (at_end) begin
                        if (c_more) begin
                            cur_r <= nxt_idx;
                        end else begin
                            // Position counted exactly; any residual speed drops at once
                            vel_r <= 16'h0000;
                            active_r <= 1'b0;
                            done_r <= 1'b1;
                            state_r <= lsmp_pkg::ST_IDLE;
                        end
                    end else if (tick_r) begin
                        if (brake) vel_r <= v_down;
                        else if (vel_r < run_sp) vel_r <= v_up;
                        else if (vel_r > run_sp) vel_r <= v_down;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign step_out = step_pulse;
    assign dir_out = dir_r;
    assign motion_active_flag = active_r;
    assign motion_done_flag = done_r;
endmodule

// [rtl/lsmp_step_gen.sv]
`timescale 1ns/100ps
`include "lsmp_consts.svh"
module lsmp_step_gen (
    input wire logic clk,
    input wire logic srst,
    input wire logic en,
    input wire logic [15:0] vel,
    output logic step
);
    logic [31:0] acc_r;
    logic step_r;

    // Phase accumulator; at most one step a cycle since vel is far below clock rate
    wire [31:0] acc_sum = acc_r + {16'h0000, vel};
    wire wrap = acc_sum >= `LSMP_CLK_HZ;

    always_ff @(posedge clk) begin
        if (srst || !en) begin
            acc_r <= 32'h00000000;
            step_r <= 1'b0;
        end else begin
            acc_r <= wrap ? acc_sum - `LSMP_CLK_HZ : acc_sum;
            step_r <= wrap;
        end
    end

    assign step = step_r;
endmodule

// [verif/lsmp_drv_model.sv]
`timescale 1ns/100ps
module lsmp_drv_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic step_out,
    input wire logic dir_out,
    output logic signed [31:0] drv_pos
);
// Shaft position as the driver sees it, apart from the design's counter
always_ff @(posedge clk) begin
    if (srst) begin
        drv_pos <= 32'sh0;
    end else if (step_out) begin
        drv_pos <= dir_out ? drv_pos + 32'sh1 : drv_pos - 32'sh1;
    end
end
endmodule

// [verif/lsmp_profiler_assertions.sv]
`timescale 1ns/100ps
module lsmp_profiler_assertions (
    input wire logic clk,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic step_out,
    input wire logic dir_out,
    input wire logic motion_active_flag,
    input wire logic motion_done_flag
);
default clocking cb @(posedge clk); endclocking
default disable iff (srst);
////////////////////////////////
sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
endsequence
chk_wr_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
chk_step_idle: assert property (step_out |-> motion_active_flag)
    else $error("step while idle");
chk_step_pulse: assert property (step_out |=> !step_out)
    else $error("step pulse too long");
chk_flags_excl: assert property (!(motion_active_flag && motion_done_flag))
    else $error("active and done together");
chk_done_cause: assert property ($fell(motion_done_flag) |-> motion_active_flag)
    else $error("done dropped without start");
chk_end_done: assert property ($fell(motion_active_flag) |-> ##[0:1] motion_done_flag)
    else $error("motion ended without done");
chk_dir_steady: assert property (motion_active_flag && $past(step_out) |-> $stable(dir_out))
    else $error("direction changed in motion");
endmodule

// [verif/testbench.sv]
`timescale 1ns/100ps
module testbench;
logic clk;
logic srst = 1'b1;
logic [7:0] awaddr = 8'h00, araddr = 8'h00;
logic [31:0] wdata = 32'h0, rdata, rd_val;
logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
logic awready, wready, bvalid, arready, rvalid, step_out, dir_out, act, done;
logic [1:0] bresp, rresp, rd_resp, wr_resp;
logic signed [31:0] drv_pos;
int n_mismatch = 0, checks_done = 0, cyc = 0;
lsmp_profiler #(.TICK_CYC(50)) lsmp_profiler_i (.clk(clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .step_out(step_out), .dir_out(dir_out), .motion_active_flag(act),
    .motion_done_flag(done));
lsmp_drv_model lsmp_drv_model_i (.clk(clk), .srst(srst), .step_out(step_out),
    .dir_out(dir_out), .drv_pos(drv_pos));
initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
end
// Longest motion is 12 steps, under ten thousand cycles; ceiling leaves margin
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t run timeout", $time);
        complete_run();
    end
end
////////////////////////////////
task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask
task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
        @(posedge clk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) break;
    end
    wr_resp = bresp;
    bready <= 1'b0;
endtask
task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
        @(posedge clk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) break;
    end
    rd_val = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    cmp(rd_val, exp);
endtask
task automatic seg(input logic [1:0] i, input logic [15:0] spd, input logic [31:0] tgt,
        input logic [1:0] flg);
    wr(8'h40 + {2'h0, i, 4'h0}, {16'h0, spd});
    wr(8'h44 + {2'h0, i, 4'h0}, tgt);
    wr(8'h48 + {2'h0, i, 4'h0}, {30'h0, flg});
endtask
task automatic wait_done();
    int n;
    n = 0;
    while (!(done === 1'b1 && act === 1'b0) && n < 40000) begin
        @(posedge clk);
        n = n + 1;
    end
    if (n == 40000) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t motion end timeout", $time);
    end
endtask
////////////////////////////////
task automatic t_reset();
    rdc(8'h08, 32'h00000064);
    rdc(8'h0c, 32'h00000064);
    rdc(8'h10, 32'h00000064);
    rdc(8'h04, 32'h00000000);
    wr(8'h4c, 32'h0000ffff);
    cmp({30'h0, wr_resp}, 32'h00000002);
    wr(8'h42, 32'h00001234);
    cmp({30'h0, wr_resp}, 32'h00000002);
    rdc(8'h40, 32'h00000000);
    rdc(8'h4c, 32'h00000000);
    cmp({30'h0, rd_resp}, 32'h00000002);
endtask
task automatic t_chain();
    wr(8'h08, 32'h0000ff00);
    cmp({30'h0, wr_resp}, 32'h00000000);
    wr(8'h0c, 32'h00000002);
    wr(8'h10, 32'h00000002);
    seg(2'h1, 16'hffff, 32'h00000008, 2'h3);
    seg(2'h2, 16'hfff0, 32'h0000000c, 2'h0);
    wr(8'h00, 32'h00000003);
    cmp({31'h0, act}, 32'h00000001);
    wr(8'h64, 32'h00000063);
    wr(8'h00, 32'h00000010);
    rdc(8'h04, 32'h00000009);
    wr(8'h00, 32'h00000001);
    rdc(8'h04, 32'h0000000d);
    wait_done();
    rdc(8'h04, 32'h00000006);
    rdc(8'h14, 32'h0000000c);
    cmp(drv_pos, 32'h0000000c);
    wr(8'h00, 32'h00000020);
endtask
task automatic t_last();
    seg(2'h3, 16'hffff, 32'hfffffffc, 2'h3);
    rdc(8'h78, 32'h00000001);
    wr(8'h00, 32'h00000007);
    wait_done();
    rdc(8'h14, 32'h00000008);
    cmp(drv_pos, 32'h00000008);
    cmp({31'h0, dir_out}, 32'h00000000);
    cmp({31'h0, done}, 32'h00000001);
endtask
task automatic t_mixed();
    seg(2'h0, 16'hffff, 32'h00000005, 2'h3);
    wr(8'h54, 32'hfffffffe);
    wr(8'h58, 32'h00000001);
    wr(8'h00, 32'h00000009);
    wait_done();
    rdc(8'h04, 32'h00007012);
    wr(8'h00, 32'h00000020);
    wr(8'h00, 32'h00000001);
    wait_done();
    rdc(8'h04, 32'h00000006);
    cmp(drv_pos, 32'h00000008);
endtask
initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_chain();
    t_last();
    t_mixed();
    complete_run();
end
endmodule
bind lsmp_profiler lsmp_profiler_assertions lsmp_profiler_assertions_i (.clk(clk),
    .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .step_out(step_out), .dir_out(dir_out),
    .motion_active_flag(motion_active_flag), .motion_done_flag(motion_done_flag));
